// ==== logic/rotate_subtract_skip_datapath.sv ====
// Rotate, subtract, set and skip slice of an 8-bit core, with its data memory.
// Assumes an AXI4-Lite master on CORE_CLK and a fetch sequencer that reads SKIP.
// Operation
// - rotate left into accumulator, bit 7 wraps to bit 0, nothing else changes.
// - nine-bit left rotate through carry back to memory, only carry changes.
// - nine-bit left rotate through carry into accumulator, memory kept.
// - rotate right back to memory, bit 0 wraps to bit 7, no flags.
// - rotate right into accumulator, memory and flags kept.
// - nine-bit right rotate through carry back to memory, only carry changes.
// - nine-bit right rotate through carry into accumulator, carry gets bit 0.
// - accumulator gets acc plus inverted operand plus carry, four flags updated.
// - memory gets acc plus inverted operand plus carry, four flags updated.
// - memory minus one to memory or accumulator, skip with dummy cycle when zero, no flags.
// - byte set writes all ones to memory, flags kept.
// - bit set forces only the selected bit to one.
// - memory plus one to memory, skip with dummy cycle when zero.
// - memory plus one to accumulator, skip when zero.
// - skip with dummy cycle when the selected bit is one.
// - acc plus inverted operand plus one, to accumulator or memory, flags updated.
// - acc plus inverted immediate plus one to accumulator, flags updated.
`timescale 1ns/1ps
`include "datapath_defs.svh"
module rotate_subtract_skip_datapath #(
	parameter int ADDR_W = 12,
	parameter int MEM_DEPTH = 64
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic SKIP,
	output logic BUSY
);
	import datapath_pkg::*;
	localparam int IDX_W = $clog2(MEM_DEPTH);
	localparam logic [ADDR_W-1:0] MEM_LO = ADDR_W'(`MEM_BASE);
	localparam logic [ADDR_W-1:0] MEM_HI = ADDR_W'(`MEM_BASE + 4 * MEM_DEPTH);

	state_t state_r, state_nxt;
	logic [7:0] mem [MEM_DEPTH];
	logic [7:0] acc_r;
	logic [3:0] flags_r, flags_nxt;
	logic [23:0] cmd_r;
	logic skip_last_r, skip_r, busy_r;
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic aw_got_r, w_got_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r, wdata_r;
	logic [3:0] wstrb_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [7:0] res;
	logic to_mem, to_acc, new_c, arith, skip;

	// Command fields
	wire op_t op = op_t'(cmd_r[`CMD_OP_LSB +: 5]);
	wire [2:0] bit_sel = cmd_r[`CMD_BIT_LSB +: 3];
	wire [IDX_W-1:0] mem_idx = cmd_r[`CMD_ADDR_LSB +: IDX_W];
	wire [7:0] imm = cmd_r[`CMD_IMM_LSB +: 8];
	wire [7:0] opnd = mem[mem_idx];
	wire cy = flags_r[`FLG_C];
	wire ex = (state_r == S_EXEC);

	// Subtract as acc + ~rhs + cin, split at bit 3 for the half carry
	wire sub_imm = (op == OP_SUBTRACT_IMMEDIATE);
	wire borrow_op = (op == OP_SUBTRACT_WITH_BORROW) || (op == OP_SUBTRACT_WITH_BORROW_TO_MEMORY);
	wire [7:0] sub_rhs = ~(sub_imm ? imm : opnd);
	wire sub_cin = borrow_op ? cy : 1'b1;
	wire [4:0] lo_sum = {1'b0, acc_r[3:0]} + {1'b0, sub_rhs[3:0]} + {4'h0, sub_cin};
	wire [4:0] hi_sum = {1'b0, acc_r[7:4]} + {1'b0, sub_rhs[7:4]} + {4'h0, lo_sum[4]};
	wire [7:0] diff = {hi_sum[3:0], lo_sum[3:0]};
	wire diff_ov = (acc_r[7] == sub_rhs[7]) && (diff[7] != acc_r[7]);
	wire [7:0] inc_v = opnd + 8'h01;
	wire [7:0] dec_v = opnd - 8'h01;
	wire [7:0] bit_mask = 8'h01 << bit_sel;

	always_comb begin
		res = opnd;
		to_mem = 1'b0;
		to_acc = 1'b0;
		new_c = cy;
		arith = 1'b0;
		skip = 1'b0;
		case (op)
			OP_ROTATE_LEFT_TO_A: begin
				res = {opnd[6:0], opnd[7]};
				to_acc = 1'b1;
			end
			OP_ROTATE_LEFT_THRU_CY: begin
				res = {opnd[6:0], cy};
				new_c = opnd[7];
				to_mem = 1'b1;
			end
			OP_ROTATE_LEFT_THRU_CY_TO_A: begin
				res = {opnd[6:0], cy};
				new_c = opnd[7];
				to_acc = 1'b1;
			end
			OP_ROTATE_RIGHT: begin
				res = {opnd[0], opnd[7:1]};
				to_mem = 1'b1;
			end
			OP_ROTATE_RIGHT_TO_A: begin
				res = {opnd[0], opnd[7:1]};
				to_acc = 1'b1;
			end
			OP_ROTATE_RIGHT_THRU_CY: begin
				res = {cy, opnd[7:1]};
				new_c = opnd[0];
				to_mem = 1'b1;
			end
			OP_ROTATE_RIGHT_THRU_CY_TO_A: begin
				res = {cy, opnd[7:1]};
				new_c = opnd[0];
				to_acc = 1'b1;
			end
			OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_TO_A, OP_SUBTRACT_IMMEDIATE: begin
				res = diff;
				arith = 1'b1;
				to_acc = 1'b1;
			end
			OP_SUBTRACT_WITH_BORROW_TO_MEMORY, OP_SUBTRACT_TO_MEMORY: begin
				res = diff;
				arith = 1'b1;
				to_mem = 1'b1;
			end
			OP_DECREMENT_SKIP_IF_NULL: begin
				res = dec_v;
				skip = (dec_v == 8'h00);
				to_mem = 1'b1;
			end
			OP_DECREMENT_TO_A_SKIP_IF_NULL: begin
				res = dec_v;
				skip = (dec_v == 8'h00);
				to_acc = 1'b1;
			end
			OP_SET_BYTE: begin
				res = 8'hFF;
				to_mem = 1'b1;
			end
			OP_SET_BIT: begin
				res = opnd | bit_mask;
				to_mem = 1'b1;
			end
			OP_INCREMENT_SKIP_IF_NULL: begin
				res = inc_v;
				skip = (inc_v == 8'h00);
				to_mem = 1'b1;
			end
			OP_INCREMENT_TO_A_SKIP_IF_NULL: begin
				res = inc_v;
				skip = (inc_v == 8'h00);
				to_acc = 1'b1;
			end
			OP_SKIP_IF_BIT_ONE: begin
				skip = |(opnd & bit_mask);
			end
			default: begin
				res = opnd;
			end
		endcase
	end

	// Flags: only the subtracts touch OV, Z and AC
	assign flags_nxt = arith ? {diff_ov, diff == 8'h00, lo_sum[4], hi_sum[4]}
		: {flags_r[3:1], new_c};

	// Register bus decode
	wire aw_take = S_AXI_AWVALID && awready_r;
	wire w_take = S_AXI_WVALID && wready_r;
	wire do_wr = aw_got_r && w_got_r && !bvalid_r && (state_r == S_IDLE);
	wire aw_got_nxt = aw_take || (aw_got_r && !do_wr);
	wire w_got_nxt = w_take || (w_got_r && !do_wr);
	wire [ADDR_W-1:0] w_off = awaddr_r - MEM_LO;
	wire [IDX_W-1:0] w_idx = w_off[2 +: IDX_W];
	wire w_cmd = (awaddr_r[ADDR_W-1:2] == `OFF_CMD >> 2);
	wire w_acc = (awaddr_r[ADDR_W-1:2] == `OFF_ACC >> 2);
	wire w_flg = (awaddr_r[ADDR_W-1:2] == `OFF_FLAGS >> 2);
	wire w_sts = (awaddr_r[ADDR_W-1:2] == `OFF_STATUS >> 2);
	wire w_mem = (awaddr_r >= MEM_LO) && (awaddr_r < MEM_HI);
	wire w_ok = w_cmd || w_acc || w_flg || w_sts || w_mem;
	wire lo_lane = wstrb_r[0];
	wire start = do_wr && w_cmd && lo_lane;
	wire ar_take = S_AXI_ARVALID && arready_r;
	wire rvalid_nxt = ar_take || (rvalid_r && !S_AXI_RREADY);
	wire [ADDR_W-1:0] r_off = S_AXI_ARADDR - MEM_LO;
	wire [IDX_W-1:0] r_idx = r_off[2 +: IDX_W];
	wire r_cmd = (S_AXI_ARADDR[ADDR_W-1:2] == `OFF_CMD >> 2);
	wire r_acc = (S_AXI_ARADDR[ADDR_W-1:2] == `OFF_ACC >> 2);
	wire r_flg = (S_AXI_ARADDR[ADDR_W-1:2] == `OFF_FLAGS >> 2);
	wire r_sts = (S_AXI_ARADDR[ADDR_W-1:2] == `OFF_STATUS >> 2);
	wire r_mem = (S_AXI_ARADDR >= MEM_LO) && (S_AXI_ARADDR < MEM_HI);
	wire [31:0] r_val = r_cmd ? {8'h00, cmd_r}
		: r_acc ? {24'h00_0000, acc_r}
		: r_flg ? {28'h000_0000, flags_r}
		: r_sts ? {30'h0000_0000, busy_r, skip_last_r}
		: r_mem ? {24'h00_0000, mem[r_idx]} : 32'h0000_0000;
	wire r_ok = r_cmd || r_acc || r_flg || r_sts || r_mem;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			S_IDLE: if (start) state_nxt = S_EXEC;
			S_EXEC: state_nxt = skip ? S_DUMMY : S_IDLE;
			S_DUMMY: state_nxt = S_IDLE;
			default: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_r <= S_IDLE;
			skip_r <= 1'b0;
			busy_r <= 1'b0;
			skip_last_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			skip_r <= ex && skip;
			busy_r <= (state_nxt != S_IDLE);
			if (ex) skip_last_r <= skip;
		end
	end

	// Bus writes happen only in idle, so they never race an execute
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			acc_r <= `ACC_RST;
			flags_r <= `FLAGS_RST;
			cmd_r <= 24'h00_0000;
		end else if (ex) begin
			if (to_acc) acc_r <= res;
			flags_r <= flags_nxt;
		end else if (do_wr && lo_lane) begin
			if (w_acc) acc_r <= wdata_r[7:0];
			if (w_flg) flags_r <= wdata_r[3:0];
			if (w_cmd) cmd_r <= wdata_r[23:0];
		end
	end

	// Data memory has no reset, like the core's RAM
	always_ff @(posedge CORE_CLK) begin
		if (ex && to_mem) mem[mem_idx] <= res;
		else if (do_wr && lo_lane && w_mem) mem[w_idx] <= wdata_r[7:0];
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
			awaddr_r <= '0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			awready_r <= !aw_got_nxt;
			wready_r <= !w_got_nxt;
			bvalid_r <= do_wr || (bvalid_r && !S_AXI_BREADY);
			if (aw_take) awaddr_r <= S_AXI_AWADDR;
			if (w_take) wdata_r <= S_AXI_WDATA;
			if (w_take) wstrb_r <= S_AXI_WSTRB;
			if (do_wr) bresp_r <= w_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `RESP_OKAY;
		end else begin
			rvalid_r <= rvalid_nxt;
			arready_r <= !rvalid_nxt;
			if (ar_take) rdata_r <= r_val;
			if (ar_take) rresp_r <= r_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	assign S_AXI_AWREADY = awready_r;
	assign S_AXI_WREADY = wready_r;
	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP = bresp_r;
	assign S_AXI_ARREADY = arready_r;
	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RDATA = rdata_r;
	assign S_AXI_RRESP = rresp_r;
	assign SKIP = skip_r;
	assign BUSY = busy_r;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	sequence dummy_slot;
		SKIP && state_r == S_DUMMY ##1 !SKIP && state_r == S_IDLE;
	endsequence
	sequence no_skip;
		!SKIP && state_r == S_IDLE;
	endsequence

	rot_left_acc_a: assert property (ex && op == OP_ROTATE_LEFT_TO_A
		|=> acc_r == {$past(opnd[6:0]), $past(opnd[7])} && $stable(flags_r))
		else $error("rotate left to acc wrong");
	rot_left_cy_a: assert property (ex && op == OP_ROTATE_LEFT_THRU_CY
		|=> mem[$past(mem_idx)] == {$past(opnd[6:0]), $past(cy)} && cy == $past(opnd[7]))
		else $error("rotate left through carry wrong");
	rot_left_cya_a: assert property (ex && op == OP_ROTATE_LEFT_THRU_CY_TO_A
		|=> acc_r == {$past(opnd[6:0]), $past(cy)} && cy == $past(opnd[7]) && $stable(opnd))
		else $error("rotate left through carry to acc wrong");
	rot_right_a: assert property (ex && op == OP_ROTATE_RIGHT
		|=> mem[$past(mem_idx)] == {$past(opnd[0]), $past(opnd[7:1])} && $stable(flags_r))
		else $error("rotate right wrong");
	rot_right_acc_a: assert property (ex && op == OP_ROTATE_RIGHT_TO_A
		|=> acc_r == {$past(opnd[0]), $past(opnd[7:1])} && $stable(opnd))
		else $error("rotate right to acc wrong");
	rot_right_cy_a: assert property (ex && op == OP_ROTATE_RIGHT_THRU_CY
		|=> mem[$past(mem_idx)] == {$past(cy), $past(opnd[7:1])} && cy == $past(opnd[0]))
		else $error("rotate right through carry wrong");
	rot_right_cya_a: assert property (ex && op == OP_ROTATE_RIGHT_THRU_CY_TO_A
		|=> acc_r == {$past(cy), $past(opnd[7:1])} && cy == $past(opnd[0]))
		else $error("rotate right through carry to acc wrong");
	sub_borrow_a: assert property (ex && op == OP_SUBTRACT_WITH_BORROW
		|=> acc_r == $past(8'(acc_r - opnd - {7'h00, !cy})))
		else $error("subtract with borrow wrong");
	sub_borrow_mem_a: assert property (ex && op == OP_SUBTRACT_WITH_BORROW_TO_MEMORY
		|=> mem[$past(mem_idx)] == $past(8'(acc_r - opnd - {7'h00, !cy})))
		else $error("subtract with borrow to memory wrong");
	dec_skip_a: assert property (ex && op == OP_DECREMENT_SKIP_IF_NULL && opnd == 8'h01
		|=> dummy_slot)
		else $error("decrement skip missing dummy cycle");
	dec_acc_a: assert property (ex && op == OP_DECREMENT_TO_A_SKIP_IF_NULL
		|=> acc_r == $past(dec_v) && SKIP == ($past(opnd) == 8'h01) && $stable(flags_r))
		else $error("decrement to acc wrong");
	set_byte_a: assert property (ex && op == OP_SET_BYTE
		|=> mem[$past(mem_idx)] == 8'hFF && $stable(flags_r))
		else $error("byte set wrong");
	set_bit_a: assert property (ex && op == OP_SET_BIT
		|=> mem[$past(mem_idx)] == ($past(opnd) | (8'h01 << $past(bit_sel))))
		else $error("bit set wrong");
	inc_skip_a: assert property (ex && op == OP_INCREMENT_SKIP_IF_NULL && opnd != 8'hFF
		|=> no_skip)
		else $error("increment skip without zero");
	inc_acc_a: assert property (ex && op == OP_INCREMENT_TO_A_SKIP_IF_NULL && opnd == 8'hFF
		|=> acc_r == 8'h00 ##0 dummy_slot)
		else $error("increment to acc skip wrong");
	bit_skip_a: assert property (ex && op == OP_SKIP_IF_BIT_ONE
		|=> SKIP == $past(opnd[bit_sel]) && $stable(flags_r))
		else $error("bit skip wrong");
	sub_mem_a: assert property (ex && op == OP_SUBTRACT_TO_MEMORY
		|=> mem[$past(mem_idx)] == $past(8'(acc_r - opnd)))
		else $error("subtract to memory wrong");
	sub_imm_a: assert property (ex && op == OP_SUBTRACT_IMMEDIATE
		|=> acc_r == $past(8'(acc_r - imm)))
		else $error("subtract immediate wrong");
	sub_flags_a: assert property (ex && op == OP_SUBTRACT_TO_A
		|=> cy == ($past(acc_r) >= $past(opnd)) && flags_r[`FLG_Z] == ($past(acc_r) == $past(opnd)))
		else $error("subtract flags wrong");
endmodule

// ==== logic/datapath_defs.svh ====
// Offsets, field positions and reset values of the rotate/subtract/skip datapath.
// Assumes a 32-bit AXI4-Lite slave with byte addresses.
`ifndef DATAPATH_DEFS_SVH
`define DATAPATH_DEFS_SVH
`define OFF_CMD 12'h000
`define OFF_ACC 12'h004
`define OFF_FLAGS 12'h008
`define OFF_STATUS 12'h00C
`define MEM_BASE 12'h100
`define CMD_OP_LSB 0
`define CMD_BIT_LSB 5
`define CMD_ADDR_LSB 8
`define CMD_IMM_LSB 16
`define FLG_C 0
`define FLG_AC 1
`define FLG_Z 2
`define FLG_OV 3
`define ACC_RST 8'h00
`define FLAGS_RST 4'h0
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ==== logic/datapath_pkg.sv ====
// Types of the rotate/subtract/skip datapath: operation codes and states.
// Assumes the constants header is included where offsets are needed.
package datapath_pkg;
	typedef enum logic [4:0] {
		OP_ROTATE_LEFT_TO_A = 5'h01,
		OP_ROTATE_LEFT_THRU_CY = 5'h02,
		OP_ROTATE_LEFT_THRU_CY_TO_A = 5'h03,
		OP_ROTATE_RIGHT = 5'h04,
		OP_ROTATE_RIGHT_TO_A = 5'h05,
		OP_ROTATE_RIGHT_THRU_CY = 5'h06,
		OP_ROTATE_RIGHT_THRU_CY_TO_A = 5'h07,
		OP_SUBTRACT_WITH_BORROW = 5'h08,
		OP_SUBTRACT_WITH_BORROW_TO_MEMORY = 5'h09,
		OP_DECREMENT_SKIP_IF_NULL = 5'h0A,
		OP_DECREMENT_TO_A_SKIP_IF_NULL = 5'h0B,
		OP_SET_BYTE = 5'h0C,
		OP_SET_BIT = 5'h0D,
		OP_INCREMENT_SKIP_IF_NULL = 5'h0E,
		OP_INCREMENT_TO_A_SKIP_IF_NULL = 5'h0F,
		OP_SKIP_IF_BIT_ONE = 5'h10,
		OP_SUBTRACT_TO_A = 5'h11,
		OP_SUBTRACT_TO_MEMORY = 5'h12,
		OP_SUBTRACT_IMMEDIATE = 5'h13
	} op_t;
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_EXEC = 2'b01,
		S_DUMMY = 2'b11
	} state_t;
endpackage

// ==== bench/fetch_model.sv ====
// Fetch sequencer stand-in: counts the dummy cycles it is told to insert.
// Assumes SKIP is a one-cycle pulse inside a busy interval on the same clock.
`timescale 1ns/1ps
module fetch_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic skip,
	input wire logic busy,
	output int skip_seen,
	output int stray
);
	// A pulse two cycles long counts twice, so the bench catches it
	always_ff @(posedge clk) begin
		if (rst) begin
			skip_seen <= 0;
			stray <= 0;
		end else if (skip === 1'b1) begin
			skip_seen <= skip_seen + 1;
			if (busy !== 1'b1) begin
				stray <= stray + 1;
			end
		end
	end
endmodule

// ==== bench/tb.sv ====
// Bench for the rotate/subtract/skip datapath: AXI4-Lite master, op model, fetch model.
// Assumes the hand-over timing; memory bytes are read only after being written.
`timescale 1ns/1ps
`include "datapath_defs.svh"
module tb;
	import datapath_pkg::*;
	logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, skip, busy;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	int skip_seen, stray, bad_count, tests_run;
	rotate_subtract_skip_datapath DUT (.CORE_CLK(clk), .RST(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.SKIP(skip), .BUSY(busy));
	fetch_model seq (.clk(clk), .rst(rst), .skip(skip), .busy(busy),
		.skip_seen(skip_seen), .stray(stray));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
			bad_count++;
		end
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic hung(input string name);
		$display("[FAIL] %s expected answer seen none", name);
		bad_count++;
		give_verdict();
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		// Idle edge so a previous bready drop never meets this raise
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
		end
		resp = bresp;
		bready <= 1'b0;
		if (n == 100) hung("write");
	endtask
	task automatic rdr(input logic [11:0] a);
		int n;
		// Idle edge so a previous rready drop never meets this raise
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
		end
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (n == 100) hung("read");
	endtask
	initial begin
		int unsigned sd;
		int op, k, idx, bi, n, base;
		logic [7:0] m, a, s, ns, ea, em, imm;
		logic [3:0] flg, ef;
		logic [8:0] sum;
		logic [4:0] lo;
		logic es, ci;
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
		bad_count = 0;
		tests_run = 0;
		sd = $urandom(32'hdafd_12c4);
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdr(`OFF_ACC);
		chk("acc reset", {24'h0, `ACC_RST}, rd);
		chk("mapped read resp", {30'h0, `RESP_OKAY}, {30'h0, resp});
		rdr(`OFF_FLAGS);
		chk("flags reset", {28'h0, `FLAGS_RST}, rd);
		rdr(12'h050);
		chk("unmapped read resp", {30'h0, `RESP_SLVERR}, {30'h0, resp});
		chk("unmapped read data", 32'h0000_0000, rd);
		wr(12'h050, 32'h0000_00a5, 4'hf);
		chk("unmapped write resp", {30'h0, `RESP_SLVERR}, {30'h0, resp});
		// Opcode 0x14 is undefined: must leave everything alone, no skip
		for (op = 0; op < 21; op++) begin
			for (k = 0; k < 5; k++) begin
				idx = $urandom_range(63);
				bi = $urandom_range(7);
				imm = 8'($urandom);
				a = 8'($urandom);
				flg = 4'($urandom);
				case (k)
					0: m = 8'h00;
					1: m = 8'h01;
					2: m = 8'hff;
					3: m = 8'h80;
					default: m = 8'($urandom);
				endcase
				ea = a;
				em = m;
				ef = flg;
				es = 1'b0;
				case (op)
					1: ea = {m[6:0], m[7]};
					2: {ef[0], em} = {m, flg[0]};
					3: {ef[0], ea} = {m, flg[0]};
					4: em = {m[0], m[7:1]};
					5: ea = {m[0], m[7:1]};
					6: {em, ef[0]} = {flg[0], m};
					7: {ea, ef[0]} = {flg[0], m};
					8, 9, 17, 18, 19: begin
						s = (op == 19) ? imm : m;
						ns = ~s;
						ci = (op < 10) ? flg[0] : 1'b1;
						sum = a + ns + ci;
						lo = a[3:0] + ns[3:0] + ci;
						ef = {(a[7] == ns[7]) && (sum[7] != a[7]), sum[7:0] == 8'h00, lo[4], sum[8]};
						if (op == 9 || op == 18) em = sum[7:0];
						else ea = sum[7:0];
					end
					10: {em, es} = {m - 8'h01, m == 8'h01};
					11: {ea, es} = {m - 8'h01, m == 8'h01};
					12: em = 8'hff;
					13: em[bi] = 1'b1;
					14: {em, es} = {m + 8'h01, m == 8'hff};
					15: {ea, es} = {m + 8'h01, m == 8'hff};
					16: es = m[bi];
					default: ;
				endcase
				wr(12'(`MEM_BASE + 4 * idx), {24'h0, m}, 4'hf);
				wr(`OFF_ACC, {24'h0, a}, 4'hf);
				wr(`OFF_FLAGS, {28'h0, flg}, 4'hf);
				base = skip_seen;
				wr(`OFF_CMD, {8'h00, imm, 2'b00, 6'(idx), 3'(bi), 5'(op)}, 4'hf);
				for (n = 0; n < 10; n++) begin
					@(posedge clk);
					if (busy === 1'b0) break;
				end
				if (n == 10) hung("busy");
				rdr(`OFF_ACC);
				chk("acc", {24'h0, ea}, rd);
				rdr(`OFF_FLAGS);
				chk("flags", {28'h0, ef}, rd);
				rdr(12'(`MEM_BASE + 4 * idx));
				chk("memory", {24'h0, em}, rd);
				rdr(`OFF_STATUS);
				chk("status", {31'h0, es}, rd);
				chk("skip pulses", {31'h0, es}, 32'(skip_seen - base));
			end
		end
		// Byte lane zero off: write dropped, still answered OKAY
		wr(`OFF_ACC, 32'h0000_005a, 4'he);
		chk("masked write resp", {30'h0, `RESP_OKAY}, {30'h0, resp});
		rdr(`OFF_ACC);
		chk("masked write acc", {24'h0, ea}, rd);
		chk("skip outside busy", 32'h0000_0000, 32'(stray));
		give_verdict();
	end
endmodule
